// >>> ccpm_chk.sv
`timescale 1ns/100ps
`default_nettype none
// Pin-level watcher for the clock and power block
module ccpm_chk
  import ccpm_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire ccpm_wb_req_s wb_req_in,
  input wire logic wb_ack_out,
  input wire logic [31:0] wb_dat_out,
  input wire logic [2:0] osc_mode_in,
  input wire logic osc_input_pin_oe_out,
  input wire logic xtal_drive_out,
  input wire logic cpu_clk_en_out,
  input wire logic fetch_en_out,
  input wire logic periph_clk_en_out,
  input wire logic clkgen_run_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Cycles since reset, and since the oscillator last stood still
  logic [11:0] since_rst;
  logic [11:0] since_run;
  // Saturating so a long run never wraps into the gated window
  always_ff @(posedge clk_in) begin
    since_rst <= rst_in ? 12'h000 : since_rst + {11'h000, ~&since_rst};
    since_run <= (rst_in | ~clkgen_run_out) ? 12'h000 :
      since_run + {11'h000, ~&since_run};
  end
  AST_ACK_NEXT: assert property (
    wb_req_in.cyc && wb_req_in.stb && !wb_ack_out |=> wb_ack_out)
    else $error("bus request not answered next cycle");
  AST_DAT_IDLE: assert property (
    !wb_ack_out |-> wb_dat_out == 32'h0) else $error("read data without ack");
  AST_TICK_RUN: assert property (
    cpu_clk_en_out |-> periph_clk_en_out && clkgen_run_out)
    else $error("cpu tick while peripherals halted");
  AST_STOP_HALT: assert property (
    !clkgen_run_out && $past(!clkgen_run_out) |->
    !periph_clk_en_out && !xtal_drive_out && !cpu_clk_en_out)
    else $error("activity while stopped");
  AST_FETCH_TICK: assert property (
    fetch_en_out |-> cpu_clk_en_out) else $error("fetch off a cpu tick");
  AST_EXT_PAD: assert property (
    osc_mode_in == CCPM_OSC_EXT_CLK |-> !osc_input_pin_oe_out)
    else $error("clock input pad driven");
  AST_FAST_PADS: assert property (
    osc_mode_in == CCPM_OSC_FAST |-> !xtal_drive_out)
    else $error("crystal driven in fast internal mode");
  AST_RESET_WARM: assert property (
    since_rst < 12'h7ff |-> !cpu_clk_en_out)
    else $error("cpu released before reset warm-up");
  AST_WAKE_WARM: assert property (
    since_run < 12'h03f |-> !cpu_clk_en_out)
    else $error("cpu released before wake warm-up");
  COV_STOP: cover property (!clkgen_run_out);
  COV_IDLE: cover property (periph_clk_en_out && !cpu_clk_en_out [*8]);
  COV_FETCH: cover property (fetch_en_out ##1 !fetch_en_out);
endmodule : ccpm_chk
bind ccpm_top ccpm_chk ccpm_chk_i (.clk_in, .rst_in, .wb_req_in,
  .wb_ack_out, .wb_dat_out, .osc_mode_in, .osc_input_pin_oe_out,
  .xtal_drive_out, .cpu_clk_en_out, .fetch_en_out, .periph_clk_en_out,
  .clkgen_run_out);
`default_nettype wire

// >>> ccpm_pads.sv
`timescale 1ns/100ps
`default_nettype none
// Slow RC oscillator and the two shared oscillator pads
module ccpm_pads
(
  input wire logic clk_in,
  input wire logic xtal_in,
  input wire logic in_oe_in,
  input wire logic in_dat_in,
  input wire logic out_oe_in,
  input wire logic out_dat_in,
  input wire logic gin_oe_in,
  input wire logic gin_dat_in,
  input wire logic gout_oe_in,
  input wire logic gout_dat_in,
  output logic pad_in_out,
  output logic pad_out_out,
  output logic slow_osc_out
);
  // Undriven pads flip each cycle so a stale level never passes
  logic wiggle = 1'b0;
  always_ff @(posedge clk_in) wiggle <= ~wiggle;
  // Slow oscillator runs free, 20 fast cycles a period
  initial begin
    slow_osc_out = 1'b0;
    forever #50 slow_osc_out = ~slow_osc_out;
  end
  // A driven crystal swings the input pad at the slow rate
  assign pad_in_out = xtal_in ? slow_osc_out :
    in_oe_in ? in_dat_in : gin_oe_in ? gin_dat_in : wiggle;
  assign pad_out_out = out_oe_in ? out_dat_in :
    gout_oe_in ? gout_dat_in : wiggle;
endmodule : ccpm_pads
`default_nettype wire

// >>> ccpm_pkg.sv
package ccpm_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] CCPM_OFS_MEM_TIMING = 8'h00;
  localparam logic [7:0] CCPM_OFS_DIV_SELECT = 8'h04;
  localparam logic [7:0] CCPM_OFS_APPLY_CMD = 8'h08;
  localparam logic [7:0] CCPM_OFS_POWER_CTRL = 8'h0c;
  localparam logic [7:0] CCPM_OFS_STATUS = 8'h10;

  // Reset values
  localparam logic [6:0] CCPM_RST_MEM_TIMING = 7'h71;
  localparam logic [2:0] CCPM_RST_DIV_SELECT = 3'h7;
  localparam logic [3:0] CCPM_RST_POWER_CTRL = 4'h8;

  // Field positions
  localparam int CCPM_FETCH_LSB = 4;
  localparam int CCPM_PCTL_IDLE = 0;
  localparam int CCPM_PCTL_STOP = 1;
  localparam int CCPM_ST_DIV_LSB = 0;
  localparam int CCPM_ST_MODE_LSB = 3;
  localparam int CCPM_ST_IDLE = 8;
  localparam int CCPM_ST_STOP = 9;
  localparam int CCPM_ST_WARM = 10;

  // Apply command key
  localparam logic [7:0] CCPM_APPLY_KEY = 8'h69;

  // Oscillator source strap codes
  localparam logic [2:0] CCPM_OSC_FAST = 3'h0;
  localparam logic [2:0] CCPM_OSC_FAST_RTC = 3'h1;
  localparam logic [2:0] CCPM_OSC_XTAL_HIGH = 3'h2;
  localparam logic [2:0] CCPM_OSC_XTAL_LOW = 3'h3;
  localparam logic [2:0] CCPM_OSC_EXT_CLK = 3'h4;

  // Warm-up counts in oscillator and slow oscillator cycles
  localparam logic [11:0] CCPM_WARM_XTAL_FAST = 12'h800;
  localparam logic [11:0] CCPM_WARM_RC_FAST = 12'h040;
  localparam logic [2:0] CCPM_WARM_SLOW = 3'h5;

  // Power states
  typedef enum logic [2:0] {
    CCPM_RESET_WARM,
    CCPM_NORMAL,
    CCPM_IDLE,
    CCPM_STOP,
    CCPM_WAKE_WARM
  } ccpm_state_e;

  // Classic Wishbone request bundle
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } ccpm_wb_req_s;

endpackage : ccpm_pkg

// >>> ccpm_top.sv
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module ccpm_top
  import ccpm_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire ccpm_wb_req_s wb_req_in,
  output logic wb_ack_out,
  output logic [31:0] wb_dat_out,
  input wire logic [2:0] osc_mode_in,
  input wire logic slow_osc_in,
  input wire logic [7:0] port_zero_in,
  input wire logic [7:0] port_one_in,
  input wire logic irq_event_in,
  input wire logic osc_input_pin_in,
  output logic osc_input_pin_out,
  output logic osc_input_pin_oe_out,
  input wire logic osc_output_pin_in,
  output logic osc_output_pin_out,
  output logic osc_output_pin_oe_out,
  input wire logic gpio_in_pin_dat_in,
  input wire logic gpio_in_pin_oe_in,
  output logic gpio_in_pin_level_out,
  input wire logic gpio_out_pin_dat_in,
  input wire logic gpio_out_pin_oe_in,
  output logic gpio_out_pin_level_out,
  output logic xtal_drive_out,
  output logic timer0_rtc_clk_out,
  output logic cpu_clk_en_out,
  output logic fetch_en_out,
  output logic periph_clk_en_out,
  output logic clkgen_run_out
);

  // Mask of low divider bits that must be all ones for a CPU tick
  function automatic logic [6:0] div_mask(input logic [2:0] sel);
    div_mask = 7'h7f >> sel;
  endfunction : div_mask

  // Source modes whose fast oscillator is an RC type
  function automatic logic is_rc_mode(input logic [2:0] mode);
    is_rc_mode = (mode == CCPM_OSC_FAST) || (mode == CCPM_OSC_FAST_RTC);
  endfunction : is_rc_mode

  ccpm_state_e state; // Power state
  ccpm_state_e next_state; // Next power state
  logic [6:0] mem_timing; // Fetch stretch and memory wait bits
  logic [2:0] div_select; // Divider code written by software
  logic [2:0] div_applied; // Divider code in use
  logic [3:0] power_ctrl; // Low power request and flags
  logic [3:0] next_power_ctrl; // Next power control value
  logic [2:0] osc_mode; // Latched source strap
  logic [6:0] div_cnt; // Free divider counter
  logic [2:0] fetch_cnt; // Ticks since last fetch
  logic [11:0] fast_cnt; // Warm-up fast cycle count
  logic [2:0] slow_cnt; // Warm-up slow edge count
  logic [11:0] fast_target; // Fast cycles for this warm-up

  // Synchroniser stages; first stages feed only second stages
  logic [2:0] mode_s1, mode_s2;
  logic slow_s1, slow_s2, slow_s3;
  logic [15:0] port_s1, port_s2;
  logic [15:0] port_snap; // Pin levels at low-power entry
  logic xin_s1, xin_s2;
  logic osc_output_pin_s1, osc_output_pin_s2;

  // Bus decode
  wire bus_req = wb_req_in.cyc && wb_req_in.stb && !wb_ack_out;
  // Writes land on the edge at which the master sees ack high
  wire bus_wr = wb_req_in.cyc && wb_req_in.stb && wb_ack_out &&
    wb_req_in.we && wb_req_in.sel[0];
  wire wr_mem_timing = bus_wr && (wb_req_in.adr == CCPM_OFS_MEM_TIMING);
  wire wr_div_select = bus_wr && (wb_req_in.adr == CCPM_OFS_DIV_SELECT);
  wire wr_apply = bus_wr && (wb_req_in.adr == CCPM_OFS_APPLY_CMD);
  wire wr_power_ctrl = bus_wr && (wb_req_in.adr == CCPM_OFS_POWER_CTRL);
  wire apply_hit = wr_apply && (wb_req_in.dat[7:0] == CCPM_APPLY_KEY);

  // Status word showing the block's own state
  wire [31:0] status_word = {21'h000000,
    (state == CCPM_RESET_WARM) || (state == CCPM_WAKE_WARM),
    state == CCPM_STOP, state == CCPM_IDLE, 2'h0, osc_mode, div_applied};

  // Read data selection; unmapped and write-only offsets read zero
  wire [31:0] read_word =
    (wb_req_in.adr == CCPM_OFS_MEM_TIMING) ? {25'h0000000, mem_timing} :
    (wb_req_in.adr == CCPM_OFS_DIV_SELECT) ? {29'h00000000, div_select} :
    (wb_req_in.adr == CCPM_OFS_POWER_CTRL) ? {28'h0000000, power_ctrl} :
    (wb_req_in.adr == CCPM_OFS_STATUS) ? status_word : 32'h00000000;

  // Pass-through kept as a function so the compare reads plainly
  function automatic logic [15:0] port_one_in_sync(input logic [15:0] v);
    port_one_in_sync = v;
  endfunction : port_one_in_sync

  // Clock ticks and warm-up progress
  wire cpu_tick = (div_cnt & div_mask(div_applied)) ==
    div_mask(div_applied);
  wire cpu_running = (state == CCPM_NORMAL);
  // Last tick is withheld on the edge that leaves normal mode
  wire cpu_step = cpu_running && cpu_tick && (next_state == CCPM_NORMAL);
  wire [2:0] fetch_stretch = mem_timing[CCPM_FETCH_LSB +: 3];
  wire fetch_hit = (fetch_cnt == fetch_stretch);
  wire slow_edge = slow_s2 && !slow_s3;
  wire fast_done = (fast_cnt == fast_target);
  wire warm_done = fast_done && (slow_cnt == CCPM_WARM_SLOW) ;
  wire port_change = ({port_one_in_sync(port_s2)} != port_snap);
  wire in_warm = (state == CCPM_RESET_WARM) || (state == CCPM_WAKE_WARM);

  // Pin roles per source mode
  wire mode_gpio_in = (osc_mode == CCPM_OSC_FAST);
  wire mode_gpio_out = (osc_mode == CCPM_OSC_FAST) ||
    (osc_mode == CCPM_OSC_EXT_CLK);
  wire mode_xtal = (osc_mode == CCPM_OSC_FAST_RTC) ||
    (osc_mode == CCPM_OSC_XTAL_HIGH) ||
    (osc_mode == CCPM_OSC_XTAL_LOW);

  // Power state sequencing
  always_comb begin
    next_state = state;
    case (state)
      CCPM_RESET_WARM: begin
        if (warm_done) begin
          next_state = CCPM_NORMAL;
        end
      end
      CCPM_NORMAL: begin
        // Stop takes priority when both bits are set
        if (power_ctrl[CCPM_PCTL_STOP]) begin
          next_state = CCPM_STOP;
        end else if (power_ctrl[CCPM_PCTL_IDLE]) begin
          next_state = CCPM_IDLE;
        end
      end
      CCPM_IDLE: begin
        if (port_change || irq_event_in) begin
          next_state = CCPM_NORMAL;
        end
      end
      CCPM_STOP: begin
        // Interrupts are ignored here; only pins wake
        if (port_change) begin
          next_state = CCPM_WAKE_WARM;
        end
      end
      CCPM_WAKE_WARM: begin
        if (warm_done) begin
          next_state = CCPM_NORMAL;
        end
      end
      default: begin
        next_state = CCPM_RESET_WARM;
      end
    endcase
  end

  // Power control bits; hardware clears the request on wake
  always_comb begin
    next_power_ctrl = power_ctrl;
    if ((state == CCPM_IDLE) && (next_state == CCPM_NORMAL)) begin
      next_power_ctrl[CCPM_PCTL_IDLE] = 1'b0;
    end
    if ((state == CCPM_STOP) && (next_state == CCPM_WAKE_WARM)) begin
      next_power_ctrl[CCPM_PCTL_STOP] = 1'b0;
    end
    // CPU is gated in low power, so a write never meets a clear
    if (wr_power_ctrl) begin
      next_power_ctrl = wb_req_in.dat[3:0];
    end
  end

  // Synchronisers for pins, strap and slow oscillator
  always_ff @(posedge clk_in) begin
    mode_s1 <= osc_mode_in;
    mode_s2 <= mode_s1;
    slow_s1 <= slow_osc_in;
    slow_s2 <= slow_s1;
    slow_s3 <= slow_s2;
    port_s1 <= {port_one_in, port_zero_in};
    port_s2 <= port_s1;
    xin_s1 <= osc_input_pin_in;
    xin_s2 <= xin_s1;
    osc_output_pin_s1 <= osc_output_pin_in;
    osc_output_pin_s2 <= osc_output_pin_s1;
  end

  // Snapshot of pin levels, frozen once low power is entered
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      port_snap <= 16'h0000;
    end else if (state == CCPM_NORMAL) begin
      port_snap <= port_s2;
    end
  end

  // Software registers; contents survive stop, except the stop request bit, cleared on wake
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mem_timing <= CCPM_RST_MEM_TIMING;
      div_select <= CCPM_RST_DIV_SELECT;
      div_applied <= CCPM_RST_DIV_SELECT;
      power_ctrl <= CCPM_RST_POWER_CTRL;
    end else begin
      if (wr_mem_timing) begin
        mem_timing <= wb_req_in.dat[6:0];
      end
      if (wr_div_select) begin
        div_select <= wb_req_in.dat[2:0];
      end
      // Other values in the command register are ignored
      if (apply_hit) begin
        div_applied <= div_select;
      end
      power_ctrl <= next_power_ctrl;
    end
  end

  // Wishbone answer, one cycle after the request
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
    end else begin
      wb_ack_out <= bus_req;
      wb_dat_out <= bus_req ? read_word : 32'h00000000;
    end
  end

  // State register and strap capture after reset release
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= CCPM_RESET_WARM;
      // Strap taken already in reset so pads never start in a wrong role
      osc_mode <= mode_s2;
    end else begin
      state <= next_state;
      if (state == CCPM_RESET_WARM) begin
        osc_mode <= mode_s2;
      end
    end
  end

  // Warm-up counters: fast cycles first, then slow edges
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fast_cnt <= 12'h000;
      slow_cnt <= 3'h0;
      fast_target <= CCPM_WARM_XTAL_FAST;
    end else if (in_warm) begin
      if (!fast_done) begin
        fast_cnt <= fast_cnt + 12'h001;
      end else if (slow_edge && (slow_cnt != CCPM_WARM_SLOW)) begin
        slow_cnt <= slow_cnt + 3'h1;
      end
    end else begin
      fast_cnt <= 12'h000;
      slow_cnt <= 3'h0;
      // RC sources settle faster after stop than crystals
      fast_target <= is_rc_mode(osc_mode) ? CCPM_WARM_RC_FAST :
        CCPM_WARM_XTAL_FAST;
    end
  end

  // Divider counter halts with the clock generator in stop
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      div_cnt <= 7'h00;
    end else if (state != CCPM_STOP) begin
      div_cnt <= div_cnt + 7'h01;
    end
  end

  // Fetch stretch counter and clock enables
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fetch_cnt <= 3'h0;
      cpu_clk_en_out <= 1'b0;
      fetch_en_out <= 1'b0;
      periph_clk_en_out <= 1'b0;
      clkgen_run_out <= 1'b1;
    end else begin
      cpu_clk_en_out <= cpu_step;
      fetch_en_out <= cpu_step && fetch_hit;
      if (cpu_step) begin
        fetch_cnt <= fetch_hit ? 3'h0 : fetch_cnt + 3'h1;
      end
      // Peripherals keep running in idle, not in stop or warm-up
      periph_clk_en_out <= (next_state == CCPM_NORMAL) ||
        (next_state == CCPM_IDLE);
      clkgen_run_out <= (next_state != CCPM_STOP);
    end
  end

  // Oscillator pin roles; crystal modes leave the pads undriven
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      osc_input_pin_out <= 1'b0;
      osc_input_pin_oe_out <= 1'b0;
      osc_output_pin_out <= 1'b0;
      osc_output_pin_oe_out <= 1'b0;
      gpio_in_pin_level_out <= 1'b0;
      gpio_out_pin_level_out <= 1'b0;
      xtal_drive_out <= 1'b0;
      timer0_rtc_clk_out <= 1'b0;
    end else begin
      osc_input_pin_out <= mode_gpio_in && gpio_in_pin_dat_in;
      osc_input_pin_oe_out <= mode_gpio_in && gpio_in_pin_oe_in;
      osc_output_pin_out <= mode_gpio_out && gpio_out_pin_dat_in;
      osc_output_pin_oe_out <= mode_gpio_out && gpio_out_pin_oe_in;
      gpio_in_pin_level_out <= mode_gpio_in && xin_s2;
      gpio_out_pin_level_out <= mode_gpio_out && osc_output_pin_s2;
      xtal_drive_out <= mode_xtal && (next_state != CCPM_STOP);
      // Low-speed crystal clock goes to timer zero in RTC mode
      timer0_rtc_clk_out <= (osc_mode == CCPM_OSC_FAST_RTC) &&
        xin_s2;
    end
  end

endmodule : ccpm_top

`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// Firmware and port logic acting on the clock and power block
module tb_top
  import ccpm_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  ccpm_wb_req_s req = '0;
  logic ack, cpu_en, fetch_en, periph_en, run, xtal, rtc, slow;
  logic [31:0] rdat;
  logic [2:0] mode = CCPM_OSC_FAST;
  logic [7:0] p0 = 8'h00;
  logic [7:0] p1 = 8'h00;
  logic irq = 1'b0;
  logic gin_oe = 1'b0, gin_dat = 1'b0, gout_oe = 1'b0, gout_dat = 1'b0;
  logic in_o, in_oe, out_o, out_oe, pad_in, pad_out, lvl_in, lvl_out;
  int fails = 0;
  int checks_done = 0;
  ccpm_top ccpm_top_i (.clk_in, .rst_in, .wb_req_in(req), .wb_ack_out(ack),
    .wb_dat_out(rdat), .osc_mode_in(mode), .slow_osc_in(slow),
    .port_zero_in(p0), .port_one_in(p1), .irq_event_in(irq),
    .osc_input_pin_in(pad_in), .osc_input_pin_out(in_o),
    .osc_input_pin_oe_out(in_oe), .osc_output_pin_in(pad_out),
    .osc_output_pin_out(out_o), .osc_output_pin_oe_out(out_oe),
    .gpio_in_pin_dat_in(gin_dat), .gpio_in_pin_oe_in(gin_oe),
    .gpio_in_pin_level_out(lvl_in), .gpio_out_pin_dat_in(gout_dat),
    .gpio_out_pin_oe_in(gout_oe), .gpio_out_pin_level_out(lvl_out),
    .xtal_drive_out(xtal), .timer0_rtc_clk_out(rtc),
    .cpu_clk_en_out(cpu_en), .fetch_en_out(fetch_en),
    .periph_clk_en_out(periph_en), .clkgen_run_out(run));
  ccpm_pads ccpm_pads_i (.clk_in, .xtal_in(xtal), .in_oe_in(in_oe),
    .in_dat_in(in_o), .out_oe_in(out_oe), .out_dat_in(out_o),
    .gin_oe_in(gin_oe), .gin_dat_in(gin_dat), .gout_oe_in(gout_oe),
    .gout_dat_in(gout_dat), .pad_in_out(pad_in), .pad_out_out(pad_out),
    .slow_osc_out(slow));
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  // Hang guard, far beyond the longest expected run
  initial begin
    #300000;
    fails++;
    give_verdict();
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // One classic cycle, held until ack, then one idle cycle
  task automatic bus(input logic we, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    req <= '{1'b1, 1'b1, we, a, 4'hf, wd};
    do begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'b1);
    rd = rdat;
    cmp(n, 32'h2);
    req <= '0;
    @(posedge clk_in);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    cmp(x, e);
  endtask : rdchk
  // Wait w for a strobe, then g cycles to the next one
  task automatic gap(input logic f, output logic [31:0] w,
      output logic [31:0] g);
    w = 0;
    g = 0;
    do begin
      @(posedge clk_in);
      w++;
    end while ((f ? fetch_en : cpu_en) !== 1'b1 && w < 9000);
    do begin
      @(posedge clk_in);
      g++;
    end while ((f ? fetch_en : cpu_en) !== 1'b1 && g < 9000);
  endtask : gap
  // CPU held, peripherals and generator as given, for 30 cycles
  task automatic quiet(input logic pe, input logic rn);
    repeat (2) @(posedge clk_in);
    repeat (30) begin
      @(posedge clk_in);
      cmp({29'h0, cpu_en, periph_en, run}, {30'h0, pe, rn});
    end
  endtask : quiet
  // Strap is sampled in reset, so it only moves there
  task automatic restart(input logic [2:0] m);
    rst_in <= 1'b1;
    mode <= m;
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
  endtask : restart
  // Stale pins and irq must not wake stop; a fresh change must
  task automatic stopwake(output logic [31:0] w);
    logic [31:0] g;
    p0 <= p0 + 8'h01;
    repeat (4) @(posedge clk_in);
    wr(CCPM_OFS_POWER_CTRL, 32'h0a);
    irq <= 1'b1;
    quiet(1'b0, 1'b0);
    irq <= 1'b0;
    p0 <= p0 + 8'h01;
    gap(1'b0, w, g);
    rdchk(CCPM_OFS_POWER_CTRL, 32'h8);
  endtask : stopwake
  initial begin
    logic [31:0] w, g;
    restart(CCPM_OSC_FAST);
    gap(1'b0, w, g);
    cmp(32'(w > 2047 && w < 2300), 32'h1);
    cmp(g, 32'h1);
    rdchk(CCPM_OFS_MEM_TIMING, 32'h71);
    rdchk(CCPM_OFS_DIV_SELECT, 32'h7);
    rdchk(CCPM_OFS_POWER_CTRL, 32'h8);
    rdchk(CCPM_OFS_STATUS, 32'h7);
    rdchk(8'h14, 32'h0);
    rdchk(CCPM_OFS_APPLY_CMD, 32'h0);
    wr(CCPM_OFS_MEM_TIMING, 32'h70);
    wr(CCPM_OFS_DIV_SELECT, 32'h5);
    wr(CCPM_OFS_APPLY_CMD, 32'h69);
    wr(CCPM_OFS_MEM_TIMING, 32'h0);
    gap(1'b0, w, g);
    cmp(g, 32'h4);
    wr(CCPM_OFS_DIV_SELECT, 32'h3);
    wr(CCPM_OFS_APPLY_CMD, 32'h68);
    gap(1'b0, w, g);
    cmp(g, 32'h4);
    // Fast internal source allows codes up to 101 only; the block applies any code in any mode, and reset leaves 111 applied
    for (int c = 0; c < 6; c++) begin
      wr(CCPM_OFS_DIV_SELECT, 32'(c));
      wr(CCPM_OFS_APPLY_CMD, 32'h69);
      gap(1'b0, w, g);
      cmp(g, 32'h1 << (7 - c));
    end
    // Code 101 left applied: one CPU tick every four clocks
    for (int s = 0; s < 8; s++) begin
      wr(CCPM_OFS_MEM_TIMING, 32'(s) << 4);
      gap(1'b1, w, g);
      cmp(g, 32'((s + 1) * 4));
    end
    wr(CCPM_OFS_MEM_TIMING, 32'h0);
    wr(CCPM_OFS_POWER_CTRL, 32'h09);
    quiet(1'b1, 1'b1);
    irq <= 1'b1;
    gap(1'b0, w, g);
    irq <= 1'b0;
    cmp(32'(w < 8), 32'h1);
    rdchk(CCPM_OFS_POWER_CTRL, 32'h8);
    wr(CCPM_OFS_POWER_CTRL, 32'h09);
    quiet(1'b1, 1'b1);
    p1 <= 8'h80;
    gap(1'b0, w, g);
    cmp(32'(w < 12), 32'h1);
    stopwake(w);
    cmp(32'(w > 63 && w < 400), 32'h1);
    gin_oe <= 1'b1;
    gin_dat <= 1'b1;
    gout_oe <= 1'b1;
    gout_dat <= 1'b1;
    repeat (6) @(posedge clk_in);
    cmp({in_oe, out_oe, lvl_in, lvl_out}, 4'hf);
    gin_dat <= 1'b0;
    gout_dat <= 1'b0;
    repeat (6) @(posedge clk_in);
    cmp({in_oe, out_oe, lvl_in, lvl_out}, 4'hc);
    restart(CCPM_OSC_EXT_CLK);
    gin_dat <= 1'b1;
    gout_dat <= 1'b1;
    repeat (8) @(posedge clk_in);
    cmp({in_oe, out_oe, lvl_in, lvl_out}, 4'h5);
    gin_oe <= 1'b0;
    restart(CCPM_OSC_FAST_RTC);
    repeat (8) @(posedge clk_in);
    w = 0;
    repeat (60) begin
      @(posedge clk_in);
      w += 32'(rtc === 1'b1);
    end
    cmp(32'(w > 10 && w < 50 && xtal === 1'b1), 32'h1);
    restart(CCPM_OSC_XTAL_HIGH);
    gap(1'b0, w, g);
    wr(CCPM_OFS_DIV_SELECT, 32'h6);
    wr(CCPM_OFS_APPLY_CMD, 32'h69);
    gap(1'b0, w, g);
    cmp(g, 32'h2);
    stopwake(w);
    cmp(32'(w > 2047 && w < 2400), 32'h1);
    // Only a slow crystal may run the CPU undivided; reset leaves code 111 applied in every mode, so every source starts undivided
    restart(CCPM_OSC_XTAL_LOW);
    gap(1'b0, w, g);
    wr(CCPM_OFS_DIV_SELECT, 32'h7);
    wr(CCPM_OFS_APPLY_CMD, 32'h69);
    gap(1'b0, w, g);
    cmp(g, 32'h1);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
